/* File: eeprom_timebase_defs.vh */
`ifndef EEPROM_TIMEBASE_DEFS_VH
`define EEPROM_TIMEBASE_DEFS_VH

// ****************************************************************
// Field layout
// ****************************************************************
`define PRESCALE_W 10
`define DIV_HIGH_W 2
`define DIV_LOW_W 8
`define CTRL_W 8
`define CTRL_PGM_BIT 0
`define CTRL_AUTO_BIT 5
`define CTRL_RESET_VAL 8'h00
`define DIV_HIGH_RESET_VAL 2'h0
`define DIV_LOW_RESET_VAL 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define TICK_CNT_W 16
`define AUTO_PULSE_TICKS 16'h0028
`define SYNC_STAGES 3

`endif

/* File: extclk_edge_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Three-stage synchroniser with rising-edge detect
// ****************************************************************
module extclk_edge_sync (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire async_i,
    output reg rise_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg level_q;

    // Stage one feeds only stage two. A level counts once stages two and
    // three agree, which also drops a glitch lasting a single cycle.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
            rise_o <= 1'b0;
        end else if (ce_i) begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                level_q <= s3_q;
            rise_o <= (s2_q == s3_q) && s3_q && !level_q;
        end
    end
endmodule // extclk_edge_sync

`default_nettype wire

/* File: eeprom_timebase_auto_program.v */
// Function
// - Divide external clock for program time base
// - Ten-bit prescaler split over high, low registers
// - Divider registers reload from shadow on first enabled edge after reset
// - Automatic timing enable at control bit five
// - Auto mode times pulse, clears program bit
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_timebase_defs.vh"

module eeprom_timebase_auto_program (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire external_clock_input_i,
    input wire [`PRESCALE_W-1:0] shadow_prescale_i,
    input wire div_high_we_i,
    input wire [`DIV_HIGH_W-1:0] div_high_wdata_i,
    input wire div_low_we_i,
    input wire [`DIV_LOW_W-1:0] div_low_wdata_i,
    input wire ctrl_we_i,
    input wire [`CTRL_W-1:0] ctrl_wdata_i,
    output reg [`DIV_HIGH_W-1:0] eeprom_divider_high_o,
    output reg [`DIV_LOW_W-1:0] eeprom_divider_low_o,
    output reg [`CTRL_W-1:0] eeprom_program_control_o,
    output reg program_pulse_enable_o,
    output reg timebase_tick_o,
    output reg auto_done_o
);
    // ****************************************************************
    // Divider registers and shadow reload
    // ****************************************************************
    // Reset values are constants; the shadow word is caught on the first
    // enabled edge after release so no port feeds the asynchronous reset.
    reg load_pending_q;
    reg [`DIV_HIGH_W-1:0] div_high_d;
    reg [`DIV_LOW_W-1:0] div_low_d;

    // The load edge wins over any divider write, so software cannot race
    // the shadow copy in the first cycle after reset.
    always @* begin
        div_high_d = eeprom_divider_high_o;
        div_low_d = eeprom_divider_low_o;
        if (load_pending_q) begin
            div_high_d =
                shadow_prescale_i[`PRESCALE_W-1:`DIV_LOW_W];
            div_low_d =
                shadow_prescale_i[`DIV_LOW_W-1:0];
        end else begin
            if (div_high_we_i)
                div_high_d = div_high_wdata_i;
            if (div_low_we_i)
                div_low_d = div_low_wdata_i;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_pending_q <= 1'b1;
            eeprom_divider_high_o <= `DIV_HIGH_RESET_VAL;
            eeprom_divider_low_o <= `DIV_LOW_RESET_VAL;
        end else if (ce_i) begin
            load_pending_q <= 1'b0;
            eeprom_divider_high_o <= div_high_d;
            eeprom_divider_low_o <= div_low_d;
        end
    end

    // The two halves are joined here; a write to one half takes effect at
    // once, so software should write both before starting a pulse.
    wire [`PRESCALE_W-1:0] prescale;
    assign prescale = {eeprom_divider_high_o, eeprom_divider_low_o};

    // ****************************************************************
    // External clock time base
    // ****************************************************************
    wire ext_rise;

    // An external rising edge reaches the prescaler some four bus cycles
    // late; the delay is constant, so it shifts the time base but never
    // changes its period.
    extclk_edge_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i(external_clock_input_i),
        .rise_o(ext_rise)
    );

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    // Counting external edges keeps the tick rate independent of the bus
    // clock; the external clock must stay well below a quarter of the bus rate.
    reg [`PRESCALE_W-1:0] pre_cnt_q;
    reg [`PRESCALE_W-1:0] pre_cnt_d;
    reg tick_d;

    // A count above a freshly lowered prescale wraps on the next edge
    // instead of running round the whole ten-bit range.
    always @* begin
        pre_cnt_d = pre_cnt_q;
        tick_d = 1'b0;
        if (ext_rise) begin
            if (pre_cnt_q >= prescale) begin
                pre_cnt_d = {`PRESCALE_W{1'b0}};
                tick_d = 1'b1;
            end else begin
                pre_cnt_d = pre_cnt_q + 10'h001;
            end
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_q <= {`PRESCALE_W{1'b0}};
            timebase_tick_o <= 1'b0;
        end else if (ce_i) begin
            pre_cnt_q <= pre_cnt_d;
            timebase_tick_o <= tick_d;
        end
    end

    // ****************************************************************
    // Program control and automatic pulse timing
    // ****************************************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_TIME = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`TICK_CNT_W-1:0] tick_cnt_q;
    reg [`TICK_CNT_W-1:0] tick_cnt_d;
    reg [`CTRL_W-1:0] ctrl_d;
    reg pulse_d;
    reg done_d;
    wire auto_en;
    assign auto_en = eeprom_program_control_o[`CTRL_AUTO_BIT];
    wire pgm_now;
    assign pgm_now = eeprom_program_control_o[`CTRL_PGM_BIT];
    wire start_auto;
    // Timing starts only on the write that raises the pulse bit, so a
    // manual pulse already running is never taken over by hardware.
    assign start_auto = ctrl_we_i && ctrl_wdata_i[`CTRL_PGM_BIT] &&
        ctrl_wdata_i[`CTRL_AUTO_BIT] && !pgm_now;
    wire last_tick;
    // The count starts at zero, so the last tick is one below the total.
    assign last_tick = (tick_cnt_q == `AUTO_PULSE_TICKS - 16'h0001);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Software may rewrite the control word at any time; a write that
    // clears the pulse or auto bit aborts the timed pulse. Hardware
    // completion yields to a simultaneous software write, so a new
    // request is never lost to a stale finish.
    always @* begin
        state_d = state_q;
        tick_cnt_d = tick_cnt_q;
        ctrl_d = eeprom_program_control_o;
        done_d = 1'b0;
        if (ctrl_we_i)
            ctrl_d = ctrl_wdata_i;
        case (state_q)
            ST_IDLE: begin
                tick_cnt_d = {`TICK_CNT_W{1'b0}};
                if (start_auto)
                    state_d = ST_TIME;
            end
            ST_TIME: begin
                if (ctrl_we_i) begin
                    if (!ctrl_wdata_i[`CTRL_PGM_BIT] ||
                        !ctrl_wdata_i[`CTRL_AUTO_BIT])
                        state_d = ST_IDLE;
                end else if (!auto_en || !pgm_now) begin
                    state_d = ST_IDLE;
                end else if (timebase_tick_o) begin
                    if (last_tick) begin
                        ctrl_d[`CTRL_PGM_BIT] = 1'b0;
                        done_d = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        tick_cnt_d = tick_cnt_q + 16'h0001;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Manual mode leaves the pulse length entirely to software.
        pulse_d = ctrl_we_i ? ctrl_wdata_i[`CTRL_PGM_BIT] : pgm_now;
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            tick_cnt_q <= {`TICK_CNT_W{1'b0}};
            eeprom_program_control_o <= `CTRL_RESET_VAL;
            program_pulse_enable_o <= 1'b0;
            auto_done_o <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            tick_cnt_q <= tick_cnt_d;
            eeprom_program_control_o <= ctrl_d;
            program_pulse_enable_o <= pulse_d;
            auto_done_o <= done_d;
        end
    end
endmodule // eeprom_timebase_auto_program

`default_nettype wire

/* File: eeprom_timebase_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_timebase_defs.vh"
// ********************
// Checker
// ********************
module eeprom_timebase_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic external_clock_input_i,
    input wire logic [`PRESCALE_W-1:0] shadow_prescale_i,
    input wire logic div_high_we_i,
    input wire logic [`DIV_HIGH_W-1:0] div_high_wdata_i,
    input wire logic ctrl_we_i,
    input wire logic [`CTRL_W-1:0] ctrl_wdata_i,
    input wire logic [`DIV_HIGH_W-1:0] eeprom_divider_high_o,
    input wire logic [`DIV_LOW_W-1:0] eeprom_divider_low_o,
    input wire logic [`CTRL_W-1:0] eeprom_program_control_o,
    input wire logic program_pulse_enable_o,
    input wire logic timebase_tick_o,
    input wire logic auto_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A tick can lag its edge by five cycles, so quiet must span eight.
    sequence ext_quiet_s;
        $stable(external_clock_input_i) [*8];
    endsequence
    sequence hw_clear_s;
        !eeprom_program_control_o[0] ##1 !program_pulse_enable_o;
    endsequence
    a_tick_needs_edge: assert property (
        ext_quiet_s |-> !timebase_tick_o)
        else $error("tick without external edge");
    a_div_high_write: assert property (
        ce_i && div_high_we_i && !$past(rst_i) |=>
        eeprom_divider_high_o == $past(div_high_wdata_i))
        else $error("divider high write lost");
    a_shadow_load: assert property ($fell(rst_i) && ce_i |=>
        {eeprom_divider_high_o, eeprom_divider_low_o} == $past(shadow_prescale_i))
        else $error("divider not loaded from shadow");
    a_ctrl_write: assert property (ce_i && ctrl_we_i |=>
        eeprom_program_control_o == $past(ctrl_wdata_i))
        else $error("control write lost");
    a_auto_clear: assert property (auto_done_o |-> hw_clear_s)
        else $error("auto finish did not clear pulse");
    a_pulse_follow: assert property (ce_i |=>
        program_pulse_enable_o == ($past(ctrl_we_i) ?
        $past(ctrl_wdata_i[0]) : $past(eeprom_program_control_o[0])))
        else $error("pulse enable not following control");
    a_done_single: assert property (auto_done_o |=> !auto_done_o)
        else $error("done longer than one cycle");
endmodule // eeprom_timebase_checker

bind eeprom_timebase_auto_program eeprom_timebase_checker eeprom_timebase_checker_i (
    .clk_i, .rst_i, .ce_i, .external_clock_input_i, .shadow_prescale_i,
    .div_high_we_i, .div_high_wdata_i, .ctrl_we_i, .ctrl_wdata_i,
    .eeprom_divider_high_o, .eeprom_divider_low_o, .eeprom_program_control_o,
    .program_pulse_enable_o, .timebase_tick_o, .auto_done_o
);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_timebase_defs.vh"
// ********************
// Bench
// ********************
module tb_top;
    logic clk_i = 0, rst_i = 1, ce_i = 1, ext = 0, run = 0;
    logic hwe = 0, lwe = 0, cwe = 0, pen, tick, done;
    logic [1:0] hd = 0, dh;
    logic [7:0] ld = 0, cd = 0, dl, ctrl;
    logic [9:0] shadow = 0;
    logic [31:0] seed = 32'h00007D0B;
    int num_errors = 0, tests_run = 0, ntk = 0, ne = 0, pre = 0;
    logic [15:0] exp_q[$];
    logic [15:0] want;
    eeprom_timebase_auto_program eeprom_timebase_auto_program_i (
        .clk_i, .rst_i, .ce_i, .external_clock_input_i(ext),
        .shadow_prescale_i(shadow), .div_high_we_i(hwe),
        .div_high_wdata_i(hd), .div_low_we_i(lwe), .div_low_wdata_i(ld),
        .ctrl_we_i(cwe), .ctrl_wdata_i(cd), .eeprom_divider_high_o(dh),
        .eeprom_divider_low_o(dl), .eeprom_program_control_o(ctrl),
        .program_pulse_enable_o(pen), .timebase_tick_o(tick),
        .auto_done_o(done)
    );
    initial forever #2 clk_i = ~clk_i;
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xorshift = v ^ (v << 5);
    endfunction
    task automatic nx();
        seed = xorshift(seed);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset();
        nx();
        shadow = seed[9:0];
        rst_i = 1;
        repeat (5) @(negedge clk_i);
        rst_i = 0;
        repeat (2) @(negedge clk_i);
        chk({dh, dl}, shadow);
        chk(ctrl, 8'h00);
    endtask
    // A quiet cycle after each write keeps back-to-back calls from
    // driving a strobe twice in one time step.
    task automatic wr(input logic [1:0] k, input logic [7:0] d);
        {hwe, lwe, cwe} = 3'h4 >> k;
        hd = d[1:0];
        ld = d;
        cd = d;
        @(negedge clk_i);
        {hwe, lwe, cwe} = 3'h0;
        @(negedge clk_i);
    endtask
    // Stopping the external clock lets the sync pipe drain before the next op.
    task automatic halt();
        run = 0;
        repeat (40) @(negedge clk_i);
    endtask
    // External clock is paced off falling edges so it never races sampling.
    initial forever begin
        repeat (8) @(negedge clk_i);
        if (run) begin
            ext = 1;
            ne++;
            repeat (8) @(negedge clk_i);
            ext = 0;
        end
    end
    always @(negedge clk_i) begin
        if (tick) begin
            ntk++;
            if (ntk > 1)
                chk(16'(ne), 16'(pre + 1));
            ne = 0;
        end
        if (done) begin
            want = exp_q.size() ? exp_q.pop_front() : 16'hFFFF;
            chk(16'(ntk), want);
        end
    end
    initial begin
        do_reset();
        for (int r = 0; r < 8; r++) begin
            nx();
            wr(2'h0, {6'h00, seed[9:8]});
            wr(2'h1, seed[7:0]);
            chk({dh, dl}, seed[9:0]);
            wr(2'h0, 8'h00);
            wr(2'h1, {6'h00, seed[11:10]});
            pre = seed[11:10];
            ntk = 0;
            exp_q.push_back(`AUTO_PULSE_TICKS);
            wr(2'h2, 8'h21);
            chk(ctrl, 8'h21);
            chk(pen, 16'h0001);
            run = 1;
            for (int i = 0; i < 4000 && ctrl[0] === 1'b1; i++)
                @(negedge clk_i);
            chk(ctrl, 8'h20);
            halt();
            chk(pen, 16'h0000);
        end
        ce_i = 0;
        wr(2'h2, 8'h01);
        chk(ctrl, 8'h20);
        ce_i = 1;
        wr(2'h2, 8'h01);
        chk(pen, 16'h0001);
        run = 1;
        repeat (3000) @(negedge clk_i);
        chk(ctrl, 8'h01);
        wr(2'h2, 8'h00);
        chk(ctrl, 8'h00);
        chk(pen, 16'h0000);
        halt();
        do_reset();
        end_sim();
    end
    initial begin
        #300000;
        num_errors++;
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
